// ### rtl/rtp_pkg.sv
// Purpose: Shared constants and types for the resistive touch panel controller
// Assumes: 50 MHz core clock, byte-wide register port
// Notes:   Samples are packed as X[31:20], Y[19:8], pressure[7:0]
package rtp_pkg;
	// Clock and timing tables, times in microseconds
	localparam int unsigned CLK_MHZ    = 50;
	localparam int unsigned DETECT_US [8] = '{10, 50, 100, 500, 1000, 5000, 10000, 50000};
	localparam int unsigned SETTLE_US [8] = '{10, 100, 500, 1000, 5000, 10000, 50000, 100000};
	localparam int unsigned TRACK_DIST [8] = '{0, 4, 8, 16, 32, 64, 92, 127};
	localparam int unsigned TIMER_W    = 23;

	// Widths and depths
	localparam int unsigned COORD_W     = 12;
	localparam int unsigned Z_W         = 8;
	localparam int unsigned SAMPLE_W    = 32;
	localparam int unsigned QUEUE_DEPTH = 128;
	localparam int unsigned PTR_W       = $clog2(QUEUE_DEPTH);
	localparam int unsigned LEVEL_W     = 8;
	localparam int unsigned ACC_W       = 15;

	// Register offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h40;
	localparam logic [7:0] ADDR_CFG       = 8'h41;
	localparam logic [7:0] ADDR_WIN [4]   = '{8'h42, 8'h44, 8'h46, 8'h48};
	localparam logic [7:0] ADDR_THR       = 8'h4A;
	localparam logic [7:0] ADDR_QCS       = 8'h4B;
	localparam logic [7:0] ADDR_LEVEL     = 8'h4C;
	localparam logic [7:0] ADDR_X         = 8'h4D;
	localparam logic [7:0] ADDR_Y         = 8'h4F;
	localparam logic [7:0] ADDR_Z         = 8'h51;
	localparam logic [7:0] ADDR_FRAC      = 8'h56;
	localparam logic [7:0] ADDR_DATA_INC  = 8'h57;
	localparam logic [7:0] ADDR_DATA_FIX  = 8'hD7;
	localparam logic [7:0] ADDR_DRIVE     = 8'h58;
	localparam logic [7:0] ADDR_SHIELD    = 8'h59;

	// Field positions
	localparam int unsigned CTRL_TRACK_LSB = 4;
	localparam int unsigned CTRL_MODE_LSB  = 1;
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CFG_AVG_LSB    = 6;
	localparam int unsigned CFG_DET_LSB    = 3;
	localparam int unsigned CFG_SET_LSB    = 0;
	localparam int unsigned QCS_HOLD_BIT   = 0;

	// Reset values
	localparam logic [2:0]  TRACK_RST  = 3'h1;
	localparam logic [7:0]  CFG_RST    = 8'h00;
	localparam logic [11:0] WIN_RST [4] = '{12'hFFF, 12'hFFF, 12'h000, 12'h000};
	localparam logic [7:0]  THR_RST    = 8'h00;
	localparam logic        QHOLD_RST  = 1'b0;

	// Acquisition select codes
	localparam logic [2:0] MODE_XYZ = 3'h0;
	localparam logic [2:0] MODE_XY  = 3'h1;
	localparam logic [2:0] MODE_X   = 3'h2;
	localparam logic [2:0] MODE_Y   = 3'h3;
	localparam logic [2:0] MODE_Z   = 3'h4;

	typedef enum logic [1:0] {AXIS_X, AXIS_Y, AXIS_Z} rtp_axis_e;
endpackage

// ### rtl/rtp_queue_if.sv
// Purpose: Carrier between the acquisition logic and the sample queue
// Assumes: Both ends run on the same clock
// Notes:   Flush has priority over push and pop
`timescale 1ns/1ps
interface rtp_queue_if (
	input wire logic clk,
	input wire logic resetn
);
	import rtp_pkg::*;
	logic                ce;
	logic                push;
	logic [SAMPLE_W-1:0] push_data;
	logic                pop;
	logic                flush;
	logic [SAMPLE_W-1:0] head;
	logic [LEVEL_W-1:0]  level;
	logic                empty;
	logic                full;
	logic                overrun;
	modport producer (output ce, push, push_data, pop, flush, input clk, resetn, head, level, empty, full, overrun);
	modport store (input clk, resetn, ce, push, push_data, pop, flush, output head, level, empty, full, overrun);
endinterface

// ### rtl/rtp_sample_queue.sv
// Purpose: 128-entry sample queue with level and sticky overrun
// Assumes: Caller never pops an empty queue on purpose; such pops are ignored
// Notes:   A push into a full queue is dropped unless a pop frees room that cycle
`timescale 1ns/1ps
module rtp_sample_queue (
	// Queue port
	rtp_queue_if.store q
);
	import rtp_pkg::*;

	logic [SAMPLE_W-1:0] mem [QUEUE_DEPTH];
	logic [PTR_W-1:0]    wr_ptr;
	logic [PTR_W-1:0]    rd_ptr;
	logic [LEVEL_W-1:0]  count;
	logic                overrun;

	// Handshake decisions
	wire do_pop  = q.pop && !q.empty;
	wire do_push = q.push && (!q.full || do_pop);

	assign q.empty   = (count == '0);
	assign q.full    = (count == LEVEL_W'(QUEUE_DEPTH));
	assign q.level   = count;
	assign q.head    = mem[rd_ptr];
	assign q.overrun = overrun;

	// Storage has no reset; the pointers define what is valid
	always_ff @(posedge q.clk) begin
		if (q.ce && do_push && !q.flush) begin
			mem[wr_ptr] <= q.push_data;
		end
	end

	// Pointers, count and sticky overrun
	always_ff @(posedge q.clk) begin
		if (!q.resetn) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			count   <= '0;
			overrun <= 1'b0;
		end else if (q.ce) begin
			if (q.flush) begin
				wr_ptr  <= '0;
				rd_ptr  <= '0;
				count   <= '0;
				overrun <= 1'b0;
			end else begin
				wr_ptr  <= wr_ptr + PTR_W'(do_push);
				rd_ptr  <= rd_ptr + PTR_W'(do_pop);
				count   <= count + LEVEL_W'(do_push) - LEVEL_W'(do_pop);
				overrun <= overrun | (q.push && !do_push); // Sample lost to a full queue
			end
		end
	end
endmodule

// ### rtl/rtp_touch_ctrl.sv
// Purpose: Four-wire resistive touch panel controller with register port
// Assumes: adc_done and adc_data come from logic on clk; touch_sense is asynchronous
// Notes:   Register port is byte wide; reads answer one cycle after reg_rd
`timescale 1ns/1ps
module rtp_touch_ctrl #(
	parameter int unsigned CYC_PER_US = rtp_pkg::CLK_MHZ
) (
	// Clock, reset, enable
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          ce,
	// Register port
	input  wire logic [7:0]                    reg_addr,
	input  wire logic                          reg_wr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_rd,
	output logic      [7:0]                    reg_rdata,
	// Panel touch sense, asynchronous
	input  wire logic                          touch_sense,
	// Converter handshake
	output logic                               adc_start,
	output rtp_pkg::rtp_axis_e                 adc_axis,
	input  wire logic                          adc_done,
	input  wire logic [rtp_pkg::COORD_W-1:0]   adc_data,
	// Panel drivers
	output logic                               drive_active,
	output rtp_pkg::rtp_axis_e                 drive_axis,
	output logic                               current_limit_high,
	output logic      [3:0]                    ground_lines,
	// Status towards the interrupt logic
	output logic                               queue_level_reached,
	output logic                               touch_present
);
	import rtp_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_DETECT, ST_SETTLE, ST_CONVERT, ST_WAIT, ST_FILTER} rtp_state_e;

	rtp_state_e          state;
	rtp_state_e          next_state;
	rtp_axis_e           axis;
	logic                en;
	logic [2:0]          track;
	logic [2:0]          mode;
	logic [7:0]          cfg;
	logic [11:0]         win [4];
	logic [7:0]          thr;
	logic                qhold;
	logic [2:0]          frac;
	logic                drive;
	logic [3:0]          shield;
	logic [2:0]          sense_sync;
	logic [TIMER_W-1:0]  timer;
	logic [3:0]          reps;
	logic [ACC_W-1:0]    acc;
	logic [COORD_W-1:0]  x_val;
	logic [COORD_W-1:0]  y_val;
	logic [Z_W-1:0]      z_val;
	logic [COORD_W-1:0]  last_x;
	logic [COORD_W-1:0]  last_y;
	logic [Z_W-1:0]      last_z;
	logic                last_valid;
	logic [1:0]          byte_idx;
	logic [7:0]          rd_byte;

	rtp_queue_if qif (.clk(clk), .resetn(resetn));

	rtp_sample_queue u_queue (
		.q (qif.store)
	);

	// Axis order for each acquisition select code
	function automatic rtp_axis_e first_axis(input logic [2:0] m);
		if (m == MODE_Y) return AXIS_Y;
		if (m == MODE_Z) return AXIS_Z;
		return AXIS_X;
	endfunction

	function automatic logic last_axis(input logic [2:0] m, input rtp_axis_e a);
		unique case (m)
			MODE_XY: return a == AXIS_Y;
			MODE_X:  return a == AXIS_X;
			MODE_Y:  return a == AXIS_Y;
			MODE_Z:  return a == AXIS_Z;
			default: return a == AXIS_Z; // Unused codes end on Z, as XYZ does
		endcase
	endfunction

	function automatic logic has_x(input logic [2:0] m);
		return m == MODE_XYZ || m == MODE_XY || m == MODE_X;
	endfunction

	function automatic logic has_y(input logic [2:0] m);
		return m == MODE_XYZ || m == MODE_XY || m == MODE_Y;
	endfunction

	// Index of the last packed byte, one less than the packed length in bytes
	function automatic logic [1:0] last_byte(input logic [2:0] m);
		unique case (m)
			MODE_XYZ: return 2'h3;
			MODE_XY:  return 2'h2;
			MODE_X:   return 2'h1;
			MODE_Y:   return 2'h1;
			default:  return 2'h0;
		endcase
	endfunction

	// One byte of the packed form of a stored sample
	function automatic logic [7:0] pack_byte(input logic [2:0] m, input logic [1:0] i, input logic [SAMPLE_W-1:0] s);
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] c;
		x = s[31:20];
		y = s[19:8];
		c = (m == MODE_Y) ? y : x;
		if (m == MODE_Z) return s[7:0];
		if (m == MODE_X || m == MODE_Y) return (i == 2'h0) ? c[11:4] : {4'h0, c[3:0]};
		unique case (i)
			2'h0:    return x[11:4];
			2'h1:    return {x[3:0], y[11:8]};
			2'h2:    return y[7:0];
			default: return s[7:0];
		endcase
	endfunction

	function automatic logic [12:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
		return (a > b) ? 13'(a - b) : 13'(b - a);
	endfunction

	// Scale raw pressure so that frac low bits are fractional, saturating
	function automatic logic [Z_W-1:0] scale_z(input logic [COORD_W-1:0] raw, input logic [2:0] f);
		logic [19:0] v;
		v = (20'(raw) << f) >> 4;
		return (v > 20'hFF) ? 8'hFF : v[7:0];
	endfunction

	// Touch sense: change accepted once stages two and three agree
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sense_sync    <= 3'h0;
			touch_present <= 1'b0;
		end else if (ce) begin
			sense_sync <= {sense_sync[1:0], touch_sense};
			if (sense_sync[1] == sense_sync[2]) begin
				touch_present <= sense_sync[2];
			end
		end
	end

	// Register write and data port read decode
	wire wr_ctrl   = reg_wr && reg_addr == ADDR_CTRL;
	wire en_rise   = wr_ctrl && reg_wdata[CTRL_EN_BIT] && !en;
	wire port_addr = reg_addr == ADDR_DATA_INC || reg_addr == ADDR_DATA_FIX;
	wire port_rd   = reg_rd && port_addr && !qif.empty;
	wire pop_now   = port_rd && byte_idx == last_byte(mode);

	// Control, configuration and pin registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			en     <= 1'b0;
			track  <= TRACK_RST;
			mode   <= MODE_XYZ;
			cfg    <= CFG_RST;
			thr    <= THR_RST;
			qhold  <= QHOLD_RST;
			frac   <= 3'h0;
			drive  <= 1'b0;
			shield <= 4'h0;
		end else if (ce && reg_wr) begin
			unique case (reg_addr)
				ADDR_CTRL: begin
					en    <= reg_wdata[CTRL_EN_BIT];
					track <= reg_wdata[CTRL_TRACK_LSB +: 3];
					if (!en) begin
						mode <= reg_wdata[CTRL_MODE_LSB +: 3];
					end
					if (en_rise) begin
						qhold <= 1'b0;
					end
				end
				ADDR_CFG:    cfg    <= reg_wdata;
				ADDR_THR:    thr    <= reg_wdata;
				ADDR_QCS:    qhold  <= reg_wdata[QCS_HOLD_BIT];
				ADDR_FRAC:   frac   <= reg_wdata[2:0];
				ADDR_DRIVE:  drive  <= reg_wdata[0];
				ADDR_SHIELD: shield <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end

	// Window bounds, high byte at the even offset
	for (genvar w = 0; w < 4; w++) begin : g_win
		always_ff @(posedge clk) begin
			if (!resetn) begin
				win[w] <= WIN_RST[w];
			end else if (ce && reg_wr && reg_addr == ADDR_WIN[w]) begin
				win[w][11:8] <= reg_wdata[3:0];
			end else if (ce && reg_wr && reg_addr == ADDR_WIN[w] + 8'h01) begin
				win[w][7:0] <= reg_wdata;
			end
		end
	end

	// Timing targets from the configuration codes
	wire [2:0]         avg_code   = cfg[CFG_AVG_LSB +: 2] == 2'h0 ? 3'h0 : {1'b0, cfg[CFG_AVG_LSB +: 2]};
	wire [3:0]         avg_n      = 4'h1 << avg_code;
	wire [TIMER_W-1:0] detect_cyc = TIMER_W'(DETECT_US[cfg[CFG_DET_LSB +: 3]] * CYC_PER_US);
	wire [TIMER_W-1:0] settle_cyc = TIMER_W'(SETTLE_US[cfg[CFG_SET_LSB +: 3]] * CYC_PER_US);
	wire [TIMER_W-1:0] target     = (state == ST_DETECT) ? detect_cyc : settle_cyc;
	wire               timer_done = timer + TIMER_W'(1) >= target;

	// Filtering of a finished sample
	wire        in_x    = !has_x(mode) || (x_val >= win[2] && x_val <= win[0]);
	wire        in_y    = !has_y(mode) || (y_val >= win[3] && y_val <= win[1]);
	wire [12:0] moved   = abs_diff(x_val, last_x) + abs_diff(y_val, last_y);
	wire        far     = moved > 13'(TRACK_DIST[track]);
	wire        z_rise  = mode == MODE_XYZ && z_val > last_z;
	wire        report  = in_x && in_y && (track == 3'h0 || !last_valid || far || z_rise);

	// Sequencer: detect, settle each axis, average readings, filter
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:    if (touch_present) next_state = ST_DETECT;
			ST_DETECT:  if (!touch_present) next_state = ST_IDLE;
			            else if (timer_done) next_state = ST_SETTLE;
			ST_SETTLE:  if (timer_done) next_state = ST_CONVERT;
			ST_CONVERT: next_state = ST_WAIT;
			ST_WAIT: begin
				if (adc_done && reps + 4'h1 < avg_n) next_state = ST_CONVERT;
				else if (adc_done && last_axis(mode, axis)) next_state = ST_FILTER;
				else if (adc_done) next_state = ST_SETTLE;
			end
			ST_FILTER:  next_state = ST_IDLE;
			default:    next_state = ST_IDLE; // Two spare codes of the state register
		endcase
		if (!en) next_state = ST_IDLE;
	end

	// Sequencer registers and last reported position
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state      <= ST_IDLE;
			axis       <= AXIS_X;
			timer      <= '0;
			reps       <= 4'h0;
			acc        <= '0;
			x_val      <= '0;
			y_val      <= '0;
			z_val      <= '0;
			last_x     <= '0;
			last_y     <= '0;
			last_z     <= '0;
			last_valid <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			timer <= (next_state != state) ? '0 : timer + TIMER_W'(1);
			if (state == ST_DETECT) begin
				axis <= first_axis(mode);
			end
			if (state == ST_SETTLE) begin
				reps <= 4'h0;
				acc  <= '0;
			end
			if (state == ST_WAIT && adc_done) begin
				reps <= reps + 4'h1;
				acc  <= acc + ACC_W'(adc_data);
			end
			if (state == ST_WAIT && next_state != ST_CONVERT && next_state != ST_WAIT) begin
				unique case (axis)
					AXIS_X: x_val <= COORD_W'((acc + ACC_W'(adc_data)) >> avg_code);
					AXIS_Y: y_val <= COORD_W'((acc + ACC_W'(adc_data)) >> avg_code);
					default: z_val <= scale_z(COORD_W'((acc + ACC_W'(adc_data)) >> avg_code), frac);
				endcase
				axis <= (axis == AXIS_X && has_y(mode)) ? AXIS_Y : AXIS_Z;
			end
			if (state == ST_FILTER && report) begin
				last_x     <= x_val;
				last_y     <= y_val;
				last_z     <= z_val;
				last_valid <= 1'b1;
			end
			if (en_rise) begin
				last_valid <= 1'b0;
			end
		end
	end

	// Queue hookup; a held queue drops every push
	assign qif.ce        = ce;
	assign qif.flush     = qhold || en_rise;
	assign qif.push      = state == ST_FILTER && report && en;
	assign qif.push_data = {x_val, y_val, z_val};
	assign qif.pop       = ce && pop_now;

	// Packed byte position within the head sample
	always_ff @(posedge clk) begin
		if (!resetn) begin
			byte_idx <= 2'h0;
		end else if (ce) begin
			if (qif.flush || pop_now) begin
				byte_idx <= 2'h0;
			end else if (port_rd) begin
				byte_idx <= byte_idx + 2'h1;
			end
		end
	end

	// Read selection; a zero threshold is illegal and never trips, so status shows only empty after reset
	assign queue_level_reached = thr != 8'h00 && qif.level >= thr;
	always_comb begin
		rd_byte = 8'h00;
		unique case (reg_addr)
			ADDR_CTRL:           rd_byte = {touch_present, track, mode, en};
			ADDR_CFG:            rd_byte = cfg;
			ADDR_WIN[0]:         rd_byte = {4'h0, win[0][11:8]};
			ADDR_WIN[0] + 8'h01: rd_byte = win[0][7:0];
			ADDR_WIN[1]:         rd_byte = {4'h0, win[1][11:8]};
			ADDR_WIN[1] + 8'h01: rd_byte = win[1][7:0];
			ADDR_WIN[2]:         rd_byte = {4'h0, win[2][11:8]};
			ADDR_WIN[2] + 8'h01: rd_byte = win[2][7:0];
			ADDR_WIN[3]:         rd_byte = {4'h0, win[3][11:8]};
			ADDR_WIN[3] + 8'h01: rd_byte = win[3][7:0];
			ADDR_THR:            rd_byte = thr;
			ADDR_QCS:            rd_byte = {qif.overrun, qif.full, qif.empty, queue_level_reached, 3'h0, qhold};
			ADDR_LEVEL:          rd_byte = qif.level;
			ADDR_X:              rd_byte = {4'h0, qif.head[31:28]};
			ADDR_X + 8'h01:      rd_byte = qif.head[27:20];
			ADDR_Y:              rd_byte = {4'h0, qif.head[19:16]};
			ADDR_Y + 8'h01:      rd_byte = qif.head[15:8];
			ADDR_Z:              rd_byte = qif.head[7:0];
			ADDR_FRAC:           rd_byte = {5'h00, frac};
			ADDR_DATA_INC:       rd_byte = qif.empty ? 8'h00 : pack_byte(mode, byte_idx, qif.head);
			ADDR_DATA_FIX:       rd_byte = qif.empty ? 8'h00 : pack_byte(mode, byte_idx, qif.head);
			ADDR_DRIVE:          rd_byte = {7'h00, drive};
			ADDR_SHIELD:         rd_byte = {4'h0, shield};
			default:             rd_byte = 8'h00;
		endcase
	end

	// Read data is captured so it stands until the next read
	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_rd) begin
			reg_rdata <= rd_byte;
		end
	end

	// Converter and driver outputs
	assign adc_start          = ce && state == ST_CONVERT;
	assign adc_axis           = axis;
	assign drive_active       = state == ST_SETTLE || state == ST_CONVERT || state == ST_WAIT;
	assign drive_axis         = axis;
	assign current_limit_high = drive;
	assign ground_lines       = shield;
endmodule

// ### verification/rtp_touch_ctrl_assertions.sv
// Purpose: Port-level assertions for the touch controller
// Assumes: One clock domain, reset synchronous and active low
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module rtp_touch_ctrl_assertions #(
	parameter int unsigned CYC_PER_US = rtp_pkg::CLK_MHZ
) (
	// Clock, reset, enable
	input logic                     clk,
	input logic                     resetn,
	input logic                     ce,
	// Register port
	input logic [7:0]               reg_addr,
	input logic                     reg_wr,
	input logic [7:0]               reg_wdata,
	input logic                     reg_rd,
	input logic [7:0]               reg_rdata,
	// Panel and converter side
	input logic                     touch_sense,
	input logic                     adc_start,
	input rtp_pkg::rtp_axis_e       adc_axis,
	input logic                     adc_done,
	input logic [11:0]              adc_data,
	input logic                     drive_active,
	input rtp_pkg::rtp_axis_e       drive_axis,
	input logic                     current_limit_high,
	input logic [3:0]               ground_lines,
	input logic                     queue_level_reached,
	input logic                     touch_present
);
	import rtp_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Register reads mirror live state sampled at the read edge
	chk_touch_bit_read: assert property (reg_rd && ce && reg_addr == ADDR_CTRL |=> reg_rdata[7] == $past(touch_present))
		else $error("control top bit differs from touch state");
	chk_level_bit_read: assert property (reg_rd && ce && reg_addr == ADDR_QCS |=> reg_rdata[4] == $past(queue_level_reached))
		else $error("status level bit differs from level output");
	chk_full_empty_excl: assert property (reg_rd && ce && reg_addr == ADDR_QCS |=> !(reg_rdata[6] && reg_rdata[5]))
		else $error("queue full and empty at once");
	// Control writes reach the panel drivers at once
	chk_drive_write: assert property (ce && reg_wr && reg_addr == ADDR_DRIVE |=> current_limit_high == $past(reg_wdata[0]))
		else $error("current limit does not follow write");
	chk_shield_write: assert property (ce && reg_wr && reg_addr == ADDR_SHIELD |=> ground_lines == $past(reg_wdata[3:0]))
		else $error("grounded lines do not follow write");
	chk_reset_drivers: assert property ($rose(resetn) |-> ground_lines == 4'h0 && !current_limit_high)
		else $error("driver controls not cleared by reset");
	// A conversion only starts on a driven, settled axis
	chk_start_driven: assert property (adc_start |-> drive_active && adc_axis == drive_axis)
		else $error("conversion started on an undriven axis");
	chk_settle_gap: assert property ($rose(drive_active) |-> !adc_start [*8])
		else $error("conversion started before settling");
	chk_start_pulse: assert property (adc_start |=> !adc_start)
		else $error("start longer than one cycle");
endmodule

bind rtp_touch_ctrl rtp_touch_ctrl_assertions #(.CYC_PER_US(CYC_PER_US)) u_chk (
	.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .touch_sense(touch_sense), .adc_start(adc_start),
	.adc_axis(adc_axis), .adc_done(adc_done), .adc_data(adc_data), .drive_active(drive_active),
	.drive_axis(drive_axis), .current_limit_high(current_limit_high), .ground_lines(ground_lines),
	.queue_level_reached(queue_level_reached), .touch_present(touch_present)
);

// ### verification/rtp_adc_model.sv
// Purpose: Converter model answering each start with a per-axis value
// Assumes: One conversion in flight at a time
// Notes:   slow stretches the answer; stale data toggles every cycle
`timescale 1ns/1ps
module rtp_adc_model (
	// Clock and request
	input  wire logic         clk,
	input  wire logic         adc_start,
	input  rtp_pkg::rtp_axis_e adc_axis,
	// Answer
	output logic              adc_done,
	output logic [11:0]       adc_data,
	// Panel values and pace
	input  wire logic [11:0]  x_val,
	input  wire logic [11:0]  y_val,
	input  wire logic [11:0]  z_val,
	input  wire logic         slow
);
	import rtp_pkg::*;
	logic [2:0] wait_cnt;
	rtp_axis_e  axis_q;
	initial begin
		adc_done = 1'b0;
		adc_data = 12'h000;
		wait_cnt = 3'h0;
	end
	// Data off the pulse is inverted each cycle so a mistimed capture shows
	always @(posedge clk) begin
		adc_done <= 1'b0;
		adc_data <= ~adc_data;
		if (adc_start) begin
			wait_cnt <= slow ? 3'h6 : 3'h1;
			axis_q   <= adc_axis;
		end else if (wait_cnt != 3'h0) begin
			wait_cnt <= wait_cnt - 3'h1;
			adc_done <= (wait_cnt == 3'h1);
			if (wait_cnt == 3'h1) adc_data <= (axis_q == AXIS_X) ? x_val : (axis_q == AXIS_Y) ? y_val : z_val;
		end
	end
endmodule

// ### verification/rtp_touch_ctrl_tb.sv
// Purpose: Self-checking bench for the touch controller
// Assumes: CYC_PER_US of 1, so every wait is a few cycles
// Notes:   Reads queue their expected byte; a monitor compares
`timescale 1ns/1ps
module rtp_touch_ctrl_tb;
	import rtp_pkg::*;
	logic        clk, resetn, ce, reg_wr, reg_rd, touch_sense, slow, rd_pend;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, shield;
	logic        adc_start, adc_done, drive_active, current_limit_high, queue_level_reached, touch_present;
	rtp_axis_e   adc_axis, drive_axis;
	logic [11:0] adc_data, x_val, y_val, z_val;
	logic [3:0]  ground_lines;
	logic [7:0]  exp_q[$];
	int          n_fail, num_checks, cycles;

	rtp_touch_ctrl #(.CYC_PER_US(1)) dut (
		.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .touch_sense(touch_sense), .adc_start(adc_start),
		.adc_axis(adc_axis), .adc_done(adc_done), .adc_data(adc_data), .drive_active(drive_active),
		.drive_axis(drive_axis), .current_limit_high(current_limit_high), .ground_lines(ground_lines),
		.queue_level_reached(queue_level_reached), .touch_present(touch_present));
	rtp_adc_model adc (.clk(clk), .adc_start(adc_start), .adc_axis(adc_axis), .adc_done(adc_done),
		.adc_data(adc_data), .x_val(x_val), .y_val(y_val), .z_val(z_val), .slow(slow));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Bus cycles: one strobe edge each, driven on the falling edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = addr;
		reg_rd = 1'b1;
		exp_q.push_back(exp);
		@(negedge clk);
		reg_rd = 1'b0;
	endtask
	// Touch until the threshold is met or the wait runs out, then lift and let acquisition end
	task automatic acquire(input logic hit);
		int i;
		touch_sense = 1'b1;
		for (i = 0; i < 600 && queue_level_reached !== 1'b1; i++) @(negedge clk);
		check({7'h00, queue_level_reached}, {7'h00, hit});
		touch_sense = 1'b0;
		for (i = 0; i < 600 && (touch_present !== 1'b0 || drive_active !== 1'b0); i++) @(negedge clk);
	endtask

	// Monitor: a taken read shows its byte one edge later
	always @(posedge clk) begin
		if (rd_pend && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
		rd_pend = reg_rd;
	end
	// Hang guard, far above the nine hundred or so cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		{resetn, reg_wr, reg_rd, touch_sense, slow, rd_pend} = 6'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		ce = 1'b1;
		{n_fail, num_checks, cycles} = '0;
		x_val = 12'($urandom(32'hDBFF5468));
		y_val = 12'($urandom());
		z_val = 12'($urandom());
		shield = 8'($urandom());
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		rd(ADDR_QCS, 8'h20);
		rd(ADDR_CTRL, 8'h10);
		rd(8'h43, 8'hFF);
		rd(8'h44, 8'h0F);
		rd(8'h48, 8'h00);
		rd(ADDR_LEVEL, 8'h00);
		rd(8'h30, 8'h00);
		wr(ADDR_THR, 8'h01);
		rd(ADDR_QCS, 8'h20);
		// Hold the queue, then enable: top bit write ignored, hold released
		wr(ADDR_QCS, 8'h01);
		wr(ADDR_CTRL, 8'h91);
		rd(ADDR_CTRL, 8'h11);
		rd(ADDR_QCS, 8'h20);
		wr(ADDR_CTRL, 8'h17);
		rd(ADDR_CTRL, 8'h11);
		wr(ADDR_DRIVE, 8'h01);
		wr(ADDR_SHIELD, shield);
		check({7'h00, current_limit_high}, 8'h01);
		check({4'h0, ground_lines}, {4'h0, shield[3:0]});
		// Fast converter; a held touch at one spot stores a single sample
		acquire(1'b1);
		rd(ADDR_LEVEL, 8'h01);
		rd(ADDR_QCS, 8'h10);
		rd(ADDR_Y, {4'h0, y_val[11:8]});
		rd(ADDR_Z, z_val[11:4]);
		rd(ADDR_DATA_FIX, x_val[11:4]);
		rd(ADDR_DATA_FIX, {x_val[3:0], y_val[11:8]});
		rd(ADDR_DATA_FIX, y_val[7:0]);
		rd(ADDR_DATA_FIX, z_val[11:4]);
		rd(ADDR_LEVEL, 8'h00);
		rd(ADDR_QCS, 8'h20);
		// Slow converter, far move; then the queue reset bit discards it
		x_val = x_val ^ 12'h800;
		slow = 1'b1;
		acquire(1'b1);
		wr(ADDR_QCS, 8'h01);
		rd(ADDR_LEVEL, 8'h00);
		rd(ADDR_QCS, 8'h21);
		wr(ADDR_QCS, 8'h00);
		// Pressure only with one fractional bit: one byte per sample
		wr(ADDR_CTRL, 8'h10);
		wr(ADDR_CTRL, 8'h19);
		wr(ADDR_FRAC, 8'h01);
		acquire(1'b1);
		rd(ADDR_DATA_INC, z_val[11] ? 8'hFF : z_val[10:3]);
		rd(ADDR_LEVEL, 8'h00);
		// Y only, averaged over two; a window below the sample discards it
		y_val = y_val | 12'h800;
		wr(ADDR_CTRL, 8'h10);
		wr(ADDR_CTRL, 8'h17);
		wr(ADDR_CFG, 8'h40);
		wr(8'h44, 8'h07);
		acquire(1'b0);
		rd(ADDR_LEVEL, 8'h00);
		wr(8'h44, 8'h0F);
		acquire(1'b1);
		rd(ADDR_DATA_FIX, y_val[11:4]);
		rd(ADDR_DATA_FIX, {4'h0, y_val[3:0]});
		rd(ADDR_LEVEL, 8'h00);
		repeat (3) @(negedge clk);
		finish_test();
	end
endmodule
